/* hss_pkg.sv */
package hss_pkg;
   // Clock period of clk_i in nanoseconds
   localparam int CLK_NS = 100;
   // Standby delay, least time, in microseconds
   localparam int STBY_DELAY_US = 100;
   localparam int STBY_CYC = (STBY_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
   // Retry interval after a shutdown, in microseconds
   localparam int RETRY_US = 200;
   localparam int RETRY_CYC = (RETRY_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RETRY_W = 16;
   localparam logic [RETRY_W-1:0] RETRY_RST = RETRY_CYC[RETRY_W-1:0];

   // Register byte offsets
   localparam logic [3:0] ADR_STATUS = 4'h0;
   localparam logic [3:0] ADR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADR_IRQ_MASK = 4'h8;
   localparam logic [3:0] ADR_RETRY = 4'hC;

   // Event bit positions in the status and mask registers
   localparam int IRQ_W = 4;
   localparam int EV_SHDN = 0;
   localparam int EV_OPEN = 1;
   localparam int EV_GND = 2;
   localparam int EV_STBY = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // Status register field positions
   localparam int ST_STATE_LSB = 0;
   localparam int ST_FAULT_DET = 4;
   localparam int ST_SWITCH = 5;
   localparam int ST_GND_LOST = 6;

   // Operating states
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_STBY_DELAY = 3'b001,
      ST_DIAG = 3'b010,
      ST_ACTIVE = 3'b011,
      ST_FAULT = 3'b100
   } hss_state_e;

   // Sense multiplexer selections
   typedef enum logic [1:0] {
      MUX_LOAD = 2'b00,
      MUX_TEMP = 2'b01,
      MUX_FAULT = 2'b10
   } hss_mux_e;
endpackage

/* hss_pin_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Filtered pin levels passed from the synchroniser to the core
interface hss_pin_if;
   logic sw_on;
   logic diag_en;
   logic sense_sel;
   logic fault_hold;
   logic thermal;
   logic ilim;
   logic open_load;
   logic gnd_lost;
   modport sync_mp (output sw_on, diag_en, sense_sel, fault_hold,
      thermal, ilim, open_load, gnd_lost);
   modport core_mp (input sw_on, diag_en, sense_sel, fault_hold,
      thermal, ilim, open_load, gnd_lost);
endinterface
`default_nettype wire

/* hss_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module hss_pin_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] pins_i,
   hss_pin_if.sync_mp pin
);
   import hss_pkg::*;

   logic [W-1:0] f1_q;
   logic [W-1:0] f2_q;
   logic [W-1:0] f3_q;
   logic [W-1:0] lvl_q;

   // Three-stage chain; only the second stage reads the first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         f1_q <= '0;
         f2_q <= '0;
         f3_q <= '0;
      end else begin
         f1_q <= pins_i;
         f2_q <= f1_q;
         f3_q <= f2_q;
      end
   end

   // A change counts once stages two and three agree, so one-cycle
   // glitches that slip through the first stage are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (f2_q[i] == f3_q[i]) begin
               lvl_q[i] <= f3_q[i];
            end
         end
      end
   end

   // Bit order matches the pin vector of the core
   assign pin.sw_on = lvl_q[0];
   assign pin.diag_en = lvl_q[1];
   assign pin.sense_sel = lvl_q[2];
   assign pin.fault_hold = lvl_q[3];
   assign pin.thermal = lvl_q[4];
   assign pin.ilim = lvl_q[5];
   assign pin.open_load = lvl_q[6];
   assign pin.gnd_lost = lvl_q[7];
endmodule
`default_nettype wire

/* hss_switch_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module hss_switch_ctrl #(
   parameter int STBY_COUNT = hss_pkg::STBY_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic switch_on_i,
   input wire logic diag_enable_i,
   input wire logic sense_select_i,
   input wire logic fault_hold_i,
   input wire logic thermal_shdn_i,
   input wire logic current_limit_i,
   input wire logic open_load_i,
   input wire logic gnd_lost_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic switch_drive_o,
   output logic sense_oe_o,
   output hss_pkg::hss_mux_e sense_mux_o,
   output hss_pkg::hss_state_e state_o,
   output logic irq_o
);
   import hss_pkg::*;

   localparam int SCW = $clog2(STBY_COUNT + 1);
   localparam logic [SCW-1:0] STBY_LOAD = SCW'(STBY_COUNT - 1);

   hss_pin_if pin ();

   hss_state_e state_q;
   hss_state_e state_d;
   logic [SCW-1:0] stby_cnt_q;
   logic [RETRY_W-1:0] retry_cnt_q;
   logic [RETRY_W-1:0] retry_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] ev;
   logic open_q;
   logic gnd_q;
   logic shdn;
   logic open_det;
   logic fault_det;
   logic wb_req;
   logic wb_wr;
   logic [31:0] mask_wd;
   logic [31:0] retry_wd;

   // Returns the write data merged into old data under byte enables
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin filtering

   hss_pin_sync #(
      .W(8)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pins_i({gnd_lost_i, open_load_i, current_limit_i, thermal_shdn_i,
         fault_hold_i, sense_select_i, diag_enable_i, switch_on_i}),
      .pin(pin.sync_mp)
   );

   ////////////////////////////////////////////////////////////////////
   // Fault conditions

   // Only true shutdowns count; reverse flow has no input at all, so
   // it can neither trip the state machine nor flag a fault
   assign shdn = pin.thermal | pin.ilim;
   // Comparator is looked at only with diag high and switch low, and
   // standby has no detection at all
   assign open_det = pin.open_load & pin.diag_en & ~pin.sw_on &
      (state_q == ST_DIAG);
   assign fault_det = (state_q == ST_FAULT) | open_det;

   ////////////////////////////////////////////////////////////////////
   // Operating state machine

   // Next state; a shutdown wins from any working state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_STANDBY: begin
            if (pin.sw_on) begin
               state_d = ST_ACTIVE;
            end else if (pin.diag_en) begin
               state_d = ST_DIAG;
            end
         end
         ST_STBY_DELAY: begin
            if (pin.sw_on) begin
               state_d = ST_ACTIVE;
            end else if (pin.diag_en) begin
               state_d = ST_DIAG;
            end else if (stby_cnt_q == '0) begin
               state_d = ST_STANDBY;
            end
         end
         ST_DIAG: begin
            if (pin.sw_on) begin
               state_d = ST_ACTIVE;
            end else if (!pin.diag_en) begin
               state_d = ST_STBY_DELAY;
            end
         end
         ST_ACTIVE: begin
            // Diag pin alone never moves us out of here
            if (!pin.sw_on) begin
               state_d = pin.diag_en ? ST_DIAG : ST_STBY_DELAY;
            end
         end
         ST_FAULT: begin
            if (!shdn && !pin.fault_hold && retry_cnt_q == '0) begin
               if (pin.sw_on) begin
                  state_d = ST_ACTIVE;
               end else if (pin.diag_en) begin
                  state_d = ST_DIAG;
               end else begin
                  state_d = ST_STBY_DELAY;
               end
            end
         end
         default: state_d = ST_STANDBY;
      endcase
      if (shdn && state_q != ST_STANDBY) begin
         state_d = ST_FAULT;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_STANDBY;
      end else begin
         state_q <= state_d;
      end
   end

   // Standby delay timer, reloaded on every entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stby_cnt_q <= STBY_LOAD;
      end else if (state_q != ST_STBY_DELAY) begin
         stby_cnt_q <= STBY_LOAD;
      end else if (stby_cnt_q != '0) begin
         stby_cnt_q <= stby_cnt_q - 1'b1;
      end
   end

   // Retry timer; runs once the shutdown condition clears, a new shutdown restarts it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retry_cnt_q <= '0;
      end else if (state_q != ST_FAULT || shdn) begin
         retry_cnt_q <= retry_q;
      end else if (retry_cnt_q != '0) begin
         retry_cnt_q <= retry_cnt_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin outputs

   // Gate drive and sense mux; ground loss overrides the state machine
   // but leaves it running so operation resumes once ground is back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switch_drive_o <= 1'b0;
         sense_oe_o <= 1'b0;
         sense_mux_o <= MUX_LOAD;
         state_o <= ST_STANDBY;
      end else begin
         switch_drive_o <= (state_d == ST_ACTIVE) & ~pin.gnd_lost;
         sense_oe_o <= pin.diag_en & (state_q != ST_STANDBY);
         if (pin.sense_sel) begin
            sense_mux_o <= MUX_TEMP;
         end else if (fault_det) begin
            sense_mux_o <= MUX_FAULT;
         end else begin
            sense_mux_o <= MUX_LOAD;
         end
         state_o <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Events and interrupt

   // Edge memories for the level conditions that raise events
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         open_q <= 1'b0;
         gnd_q <= 1'b0;
      end else begin
         open_q <= open_det;
         gnd_q <= pin.gnd_lost;
      end
   end

   always_comb begin
      ev = '0;
      ev[EV_SHDN] = (state_d == ST_FAULT) & (state_q != ST_FAULT);
      ev[EV_OPEN] = open_det & ~open_q;
      ev[EV_GND] = pin.gnd_lost & ~gnd_q;
      ev[EV_STBY] = (state_d == ST_STANDBY) & (state_q != ST_STANDBY);
   end

   // Sticky status; an event in the clearing cycle still sets its bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else if (wb_wr && wb_adr_i == ADR_IRQ_STAT && wb_sel_i[0]) begin
         irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_q <= irq_stat_q | ev;
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Wishbone slave

   // Answer every access one cycle after the strobe; an unmapped
   // address still acks, writes nothing and reads zero
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Byte-lane merge of the write data into each writable register
   assign mask_wd = lane_merge({28'h0000000, irq_mask_q}, wb_dat_i, wb_sel_i);
   assign retry_wd = lane_merge({16'h0000, retry_q}, wb_dat_i, wb_sel_i);

   // Writable control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= IRQ_MASK_RST;
         retry_q <= RETRY_RST;
      end else if (wb_wr) begin
         if (wb_adr_i == ADR_IRQ_MASK) begin
            irq_mask_q <= mask_wd[IRQ_W-1:0];
         end
         if (wb_adr_i == ADR_RETRY) begin
            retry_q <= retry_wd[RETRY_W-1:0];
         end
      end
   end

   // Read data, captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= 32'h00000000;
         case (wb_adr_i)
            ADR_STATUS: begin
               wb_dat_o[ST_STATE_LSB +: 3] <= state_q;
               wb_dat_o[ST_FAULT_DET] <= fault_det;
               wb_dat_o[ST_SWITCH] <= switch_drive_o;
               wb_dat_o[ST_GND_LOST] <= pin.gnd_lost;
            end
            ADR_IRQ_STAT: wb_dat_o[IRQ_W-1:0] <= irq_stat_q;
            ADR_IRQ_MASK: wb_dat_o[IRQ_W-1:0] <= irq_mask_q;
            ADR_RETRY: wb_dat_o[RETRY_W-1:0] <= retry_q;
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   temp_route_a: assert property (
      pin.sense_sel |=> sense_mux_o == MUX_TEMP)
      else $error("temperature not routed with select high");

   hiz_sense_a: assert property (
      !pin.diag_en |=> !sense_oe_o)
      else $error("sense driven with diag low");

   fault_level_a: assert property (
      state_q == ST_FAULT && !pin.sense_sel |=> sense_mux_o == MUX_FAULT)
      else $error("fault level missing while awaiting retry");

   stby_enter_a: assert property (
      state_q == ST_STBY_DELAY && stby_cnt_q == '0 && !pin.sw_on &&
      !pin.diag_en && !shdn |=> state_q == ST_STANDBY)
      else $error("standby not reached after delay");

   stby_quiet_a: assert property (
      state_q == ST_STANDBY |-> !fault_det ##1 !sense_oe_o)
      else $error("diagnostics alive in standby");

   switch_off_a: assert property (
      state_o != ST_ACTIVE |-> !switch_drive_o)
      else $error("switch on outside active state");

   active_on_a: assert property (
      state_q == ST_ACTIVE && pin.sw_on && !shdn && !pin.gnd_lost
      |=> state_q == ST_ACTIVE && switch_drive_o)
      else $error("active state left or switch off");

   fault_enter_a: assert property (
      shdn && state_q != ST_STANDBY |=> state_q == ST_FAULT &&
      !switch_drive_o)
      else $error("shutdown did not enter fault");

   fault_stay_a: assert property (
      state_q == ST_FAULT && (pin.fault_hold || retry_cnt_q != '0)
      |=> state_q == ST_FAULT)
      else $error("fault left early");

   retry_on_a: assert property (
      state_q == ST_FAULT && !shdn && !pin.fault_hold &&
      retry_cnt_q == '0 && pin.sw_on |=> state_q == ST_ACTIVE)
      else $error("no re-enable after retry");

   gnd_off_a: assert property (
      pin.gnd_lost |=> !switch_drive_o)
      else $error("switch on with ground lost");

   open_gate_a: assert property (
      state_q != ST_FAULT && (pin.sw_on || !pin.diag_en)
      |=> sense_mux_o != MUX_FAULT)
      else $error("open load seen outside diag off");

   stby_abort_a: assert property (
      state_q == ST_STBY_DELAY && (pin.sw_on || pin.diag_en) && !shdn
      |=> state_q == ($past(pin.sw_on) ? ST_ACTIVE : ST_DIAG))
      else $error("standby delay not abandoned");
endmodule
`default_nettype wire

/* hss_mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the switch: GPIO lines driving the pins, ADC on the sense line
module hss_mcu_model #(
   parameter int SETTLE = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic switch_drive_i,
   input wire logic sense_oe_i,
   input wire logic [1:0] sense_mux_i,
   input wire logic adc_req_i,
   output logic switch_on_o,
   output logic diag_enable_o,
   output logic sense_select_o,
   output logic fault_hold_o,
   output logic adc_stb_o,
   output logic [2:0] adc_code_o
);
   logic [7:0] cnt_q;
   logic drv_q;
   logic req_q;

   ////////////////////////////////////////////////////////////////////////////
   // All GPIO lines start low, as after a port reset in firmware
   initial begin
      switch_on_o = 1'b0;
      diag_enable_o = 1'b0;
      sense_select_o = 1'b0;
      fault_hold_o = 1'b0;
   end

   // Port writes land just after an edge, never mid-cycle
   task automatic set_pins(input logic on, input logic dia, input logic sel,
      input logic hold);
      @(posedge clk_i);
      switch_on_o <= on;
      diag_enable_o <= dia;
      sense_select_o <= sel;
      fault_hold_o <= hold;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Sample only after the sense line has settled from a turn-on or request;
   // the sense resistor pulls a released line to ground, so high-z reads 0
   always_ff @(posedge clk_i) begin
      drv_q <= switch_drive_i;
      req_q <= adc_req_i;
      adc_stb_o <= 1'b0;
      if (rst_i) begin
         cnt_q <= 8'h00;
         adc_code_o <= 3'h0;
      end else if ((switch_drive_i && !drv_q) || (adc_req_i && !req_q)) begin
         cnt_q <= SETTLE[7:0];
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            adc_stb_o <= 1'b1;
            adc_code_o <= sense_oe_i ? {1'b1, sense_mux_i} : 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import hss_pkg::*;
   // Long enough that a pin change can abort the delay before it expires
   localparam int STBY = 40;
   localparam int SETTLE = 4;
   localparam int W = 10;
   logic clk_i;
   logic rst_i;
   logic therm, ilim, ol, gnd, adc_req, exp_irq, adc_stb;
   logic sw_on, dia, sel, hold, drive, oe, irq, ack, we, cyc, stb;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, r;
   logic [32:0] note;
   logic [2:0] code, enote;
   hss_mux_e mux;
   hss_state_e state;
   logic [32:0] rdq[$];
   logic [2:0] adcq[$];
   int err_total, compares;

   hss_switch_ctrl #(.STBY_COUNT(STBY)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .switch_on_i(sw_on), .diag_enable_i(dia), .sense_select_i(sel),
      .fault_hold_i(hold), .thermal_shdn_i(therm), .current_limit_i(ilim),
      .open_load_i(ol), .gnd_lost_i(gnd), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(rdat), .wb_ack_o(ack), .switch_drive_o(drive),
      .sense_oe_o(oe), .sense_mux_o(mux), .state_o(state), .irq_o(irq));

   hss_mcu_model #(.SETTLE(SETTLE)) mcu_u (.clk_i(clk_i), .rst_i(rst_i),
      .switch_drive_i(drive), .sense_oe_i(oe), .sense_mux_i(mux),
      .adc_req_i(adc_req), .switch_on_o(sw_on), .diag_enable_o(dia),
      .sense_select_o(sel), .fault_hold_o(hold), .adc_stb_o(adc_stb),
      .adc_code_o(code));

   ////////////////////////////////////////////////////////////////////////////
   // Free-running 10 MHz clock
   initial clk_i = 1'b0;
   always #50 clk_i = ~clk_i;

   task automatic end_sim();
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // An empty queue yields unknowns, so a surprise result always mismatches
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         note = (rdq.size() > 0) ? rdq.pop_front() : 33'hx;
         chk("read data", note[31:0], rdat);
         chk("irq", {31'h0, note[32]}, {31'h0, irq});
         // State and gate pins must agree with the status just read
         if (adr == ADR_STATUS) begin
            chk("state", {29'h0, note[2:0]}, {29'h0, state});
            chk("switch", {31'h0, note[ST_SWITCH]}, {31'h0, drive});
         end
      end
      if (adc_stb === 1'b1) begin
         enote = (adcq.size() > 0) ? adcq.pop_front() : 3'hx;
         chk("sense", {29'h0, enote}, {29'h0, code});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Classic single cycle; the slave's ack is the only end of the wait
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [31:0] e);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w) rdq.push_back({exp_irq, e});
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, e);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 32'h0);
   endtask

   function automatic logic [31:0] st(input logic [2:0] s, input logic f,
      input logic w, input logic g);
      return 32'(s) | (32'(f) << ST_FAULT_DET) | (32'(w) << ST_SWITCH)
         | (32'(g) << ST_GND_LOST);
   endfunction

   // Pins pass a filter, so every change is followed by a settling wait
   task automatic pin(input logic on, input logic d, input logic s,
      input logic h);
      mcu_u.set_pins(on, d, s, h);
      repeat (W) @(posedge clk_i);
   endtask

   task automatic env(input logic [3:0] v);
      @(posedge clk_i);
      {therm, ilim, ol, gnd} <= v;
      repeat (W) @(posedge clk_i);
   endtask

   task automatic sample(input logic [2:0] e);
      adcq.push_back(e);
      @(posedge clk_i) adc_req <= 1'b1;
      @(posedge clk_i) adc_req <= 1'b0;
      repeat (SETTLE + 3) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Cut a hang short well past the expected run of under a thousand cycles
   initial begin
      repeat (8000) @(posedge clk_i);
      err_total++;
      end_sim();
   end

   // Main sequence
   initial begin
      {therm, ilim, ol, gnd} = 4'h0;
      {adc_req, cyc, stb, we, exp_irq} = 5'h0;
      adr = 4'h0;
      wdat = 32'h0;
      err_total = 0;
      compares = 0;
      rst_i = 1'b1;
      r = $urandom(32'hF4C7719E);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_STATUS, 32'h0);
      rd(ADR_IRQ_STAT, 32'h0);
      rd(ADR_RETRY, 32'h0000_07D0);
      wr(ADR_IRQ_MASK, 32'h0000_000F);
      rd(ADR_IRQ_MASK, 32'h0000_000F);
      wr(ADR_IRQ_MASK, 32'h0);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0);
      env(4'h2);
      rd(ADR_STATUS, st(ST_STANDBY, 0, 0, 0));
      rd(ADR_IRQ_STAT, 32'h0);
      env(4'h0);
      adcq.push_back(3'h0);
      pin(1, 0, 0, 0);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
      // Random diag and select toggles must not leave the active state
      repeat (6) begin
         r = $urandom;
         env({2'b00, r[2], 1'b0});
         pin(1, r[0], r[1], 0);
         rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
         sample(r[0] ? {1'b1, r[1] ? MUX_TEMP : MUX_LOAD} : 3'h0);
      end
      env(4'h0);
      pin(0, 0, 0, 0);
      rd(ADR_STATUS, st(ST_STBY_DELAY, 0, 0, 0));
      pin(0, 1, 0, 0);
      repeat (2 * STBY) @(posedge clk_i);
      rd(ADR_STATUS, st(ST_DIAG, 0, 0, 0));
      rd(ADR_IRQ_STAT, 32'h0);
      wr(ADR_IRQ_STAT, 32'hF);
      pin(0, 0, 0, 0);
      rd(ADR_STATUS, st(ST_STBY_DELAY, 0, 0, 0));
      repeat (2 * STBY) @(posedge clk_i);
      rd(ADR_STATUS, st(ST_STANDBY, 0, 0, 0));
      rd(ADR_IRQ_STAT, 32'h8);
      wr(ADR_IRQ_STAT, 32'hF);
      pin(0, 1, 0, 0);
      env(4'h2);
      rd(ADR_STATUS, st(ST_DIAG, 1, 0, 0));
      sample({1'b1, MUX_FAULT});
      pin(0, 1, 1, 0);
      sample({1'b1, MUX_TEMP});
      rd(ADR_IRQ_STAT, 32'h2);
      env(4'h0);
      rd(ADR_STATUS, st(ST_DIAG, 0, 0, 0));
      wr(ADR_IRQ_STAT, 32'hF);
      // Shutdown with hold high, then released; retry shortened to 4 cycles
      wr(ADR_RETRY, 32'h4);
      wr(ADR_IRQ_MASK, 32'h1);
      adcq.push_back({1'b1, MUX_LOAD});
      pin(1, 1, 0, 1);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
      env(4'h8);
      exp_irq = 1'b1;
      rd(ADR_STATUS, st(ST_FAULT, 1, 0, 0));
      rd(ADR_IRQ_STAT, 32'h1);
      env(4'h0);
      repeat (20) @(posedge clk_i);
      rd(ADR_STATUS, st(ST_FAULT, 1, 0, 0));
      adcq.push_back({1'b1, MUX_LOAD});
      pin(1, 1, 0, 0);
      repeat (20) @(posedge clk_i);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
      env(4'h4);
      rd(ADR_STATUS, st(ST_FAULT, 1, 0, 0));
      pin(0, 1, 0, 0);
      env(4'h0);
      repeat (20) @(posedge clk_i);
      rd(ADR_STATUS, st(ST_DIAG, 0, 0, 0));
      wr(ADR_IRQ_STAT, 32'hF);
      exp_irq = 1'b0;
      rd(ADR_IRQ_STAT, 32'h0);
      // Ground loss forces the switch off while the state machine runs on
      adcq.push_back(3'h0);
      pin(1, 0, 0, 0);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
      env(4'h1);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 0, 1));
      rd(ADR_IRQ_STAT, 32'h4);
      adcq.push_back(3'h0);
      env(4'h0);
      rd(ADR_STATUS, st(ST_ACTIVE, 0, 1, 0));
      repeat (SETTLE + 4) @(posedge clk_i);
      // Every noted result must have been seen by the watcher
      chk("notes left", 32'h0, 32'(rdq.size() + adcq.size()));
      end_sim();
   end
endmodule
`default_nettype wire
